/* rtl/apm_map.vh */
/*
 * Register indices, field positions, reset values and
 * timing factors of the average power protection monitor.
 * Assumes inclusion by bare name from the rtl files.
 */
`ifndef APM_MAP_VH
`define APM_MAP_VH

// ============================================================
// register indices (byte address = 4 x index)
`define APM_IDX_PAGE        12'h008
`define APM_IDX_FADE_EN     12'h581
`define APM_IDX_LLIM_LO     12'h583
`define APM_IDX_LLIM_HI     12'h584
`define APM_IDX_LONG_CTL    12'h585
`define APM_IDX_LPWR_LO     12'h586
`define APM_IDX_LPWR_HI     12'h587
`define APM_IDX_SLIM_LO     12'h588
`define APM_IDX_SLIM_HI     12'h589
`define APM_IDX_SHORT_CTL   12'h58A
`define APM_IDX_SPWR_LO     12'h58B
`define APM_IDX_SPWR_HI     12'h58C
`define APM_IDX_INTERP      12'h5A0
`define APM_IDX_STATUS      12'h5A1
`define APM_IDX_MASK        12'h5A2

// ============================================================
// field positions
`define APM_DET_ON_BIT      7
`define APM_FADE_LONG_BIT   6
`define APM_LONG_LEN_MSB    3
`define APM_SHORT_LEN_MSB   1
`define APM_PWR_HI_MSB      4

// ============================================================
// reset values
`define APM_RST_CTL         8'h00
`define APM_RST_LIMIT       13'h0000
`define APM_RST_FADE_LONG   1'b1
`define APM_RST_PAGE        1'b0

// ============================================================
// timing and arithmetic
`define APM_LONG_BASE_EXP   5'h09
`define APM_PA_MAIN_FACTOR  8'h04
`define APM_PA_CHAN_FACTOR  8'h08
`define APM_PA_PLAIN_PERIOD 8'h20
`define APM_SAMPLE_MSBS     6

`endif

/* rtl/apm_pa_clock.v */
/*
 * PA clock tick generator: one mclk-wide pulse per PA clock
 * period. Assumes one mclk cycle per DAC clock period and
 * interpolation settings given as plain factors (1,2,3...).
 */
`timescale 1ns/100ps
`include "apm_map.vh"

module apm_pa_clock (
    // clock and reset
    input wire mclk,
    input wire rst,
    // interpolation settings
    input wire [3:0] main_interp,
    input wire [3:0] chan_interp,
    // tick out
    output reg pa_tick
);

    // ========================================================
    // period select
    function [7:0] apm_pa_period;
        input [3:0] m;
        input [3:0] c;
        begin
            if (m > 4'h1) begin
                apm_pa_period = `APM_PA_MAIN_FACTOR * {4'h0, m}; // [R3]
            end else if (c > 4'h1) begin
                apm_pa_period = `APM_PA_CHAN_FACTOR * {4'h0, m}; // [R3]
            end else begin
                apm_pa_period = `APM_PA_PLAIN_PERIOD; // [R3]
            end
        end
    endfunction

    wire [7:0] period = apm_pa_period(main_interp, chan_interp);
    reg [7:0] count;

    // ========================================================
    // divider; >= guards against a period shrunk mid-count
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            count <= 8'h00;
            pa_tick <= 1'b0;
        end else if (count >= period - 8'h01) begin
            count <= 8'h00;
            pa_tick <= 1'b1;
        end else begin
            count <= count + 8'h01;
            pa_tick <= 1'b0;
        end
    end

endmodule // apm_pa_clock

/* rtl/apm_window_avg.v */
/*
 * One averaging window: accumulates 2^shift power samples on
 * PA ticks, publishes the average and flags it above limit.
 * Assumes pa_tick is a one-cycle pulse and shift <= 24.
 */
`timescale 1ns/100ps
`include "apm_map.vh"

module apm_window_avg (
    // clock and reset
    input wire mclk,
    input wire rst,
    // control
    input wire enable,
    input wire pa_tick,
    input wire [4:0] shift,
    input wire [12:0] limit,
    // data
    input wire [11:0] power,
    // results
    output reg [12:0] avg,
    output reg err
);

    reg [24:0] count;
    reg [35:0] acc;
    wire [24:0] last = (25'h0000001 << shift) - 25'h0000001;
    wire [35:0] next_sum = acc + {24'h000000, power};
    wire [35:0] next_avg = next_sum >> shift;

    // ========================================================
    // accumulate; disabled window is idle and holds its reading
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            count <= 25'h0000000;
            acc <= 36'h000000000;
            avg <= 13'h0000;
            err <= 1'b0;
        end else if (!enable) begin
            count <= 25'h0000000; // [R1] [R7]
            acc <= 36'h000000000;
            err <= 1'b0;
        end else begin
            err <= 1'b0;
            if (pa_tick) begin
                if (count >= last) begin
                    count <= 25'h0000000;
                    acc <= 36'h000000000;
                    avg <= next_avg[12:0];
                    err <= (next_avg[12:0] > limit); // [R13]
                end else begin
                    count <= count + 25'h0000001;
                    acc <= next_sum;
                end
            end
        end
    end

endmodule // apm_window_avg

/* rtl/apm_monitor.v */
/*
 * Average power protection monitor for two main DAC paths,
 * with an APB register slave, paged per-path controls, a
 * sticky status with mask and one level interrupt.
 * Assumes I/Q samples synchronous to mclk, one per DAC clock.
 */
`timescale 1ns/100ps
`include "apm_map.vh"

// Function
// R1 - A set long detector bit runs the long average and its check.
// R2 - The long window lasts two to the nine plus field PA periods.
// R3 - PA period is 4x main, else 8x main, else 32 DAC clocks.
// R4 - Power is I squared plus Q squared on six top sample bits.
// R5 - Long average reads back as 13 bits over two registers.
// R6 - A writable 13-bit short limit checks the short average.
// R7 - A set short detector bit runs the short average and check.
// R8 - The short window lasts two to the field PA periods.
// R9 - Every field exists per path, reached through the page select; interp, status and mask are shared.
// R10 - A writable 13-bit long limit checks the long average.
// R11 - Short average reads back as 13 bits over two registers.
// R12 - A long error requests a fade-out when enabled, reset one.
// R13 - A window ending above its limit flags an error if enabled.
module apm_monitor (
    // clock and reset
    input wire mclk,
    input wire rst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // path 0 samples
    input wire [15:0] path0_i,
    input wire [15:0] path0_q,
    // path 1 samples
    input wire [15:0] path1_i,
    input wire [15:0] path1_q,
    // protection outputs
    output reg [1:0] fade_request,
    output reg irq
);

    // ========================================================
    // power of one sample from its top bits
    function [11:0] apm_iq_power;
        input [5:0] a;
        input [5:0] b;
        reg [5:0] ma;
        reg [5:0] mb;
        begin
            ma = a[5] ? (6'h00 - a) : a;
            mb = b[5] ? (6'h00 - b) : b;
            apm_iq_power = {6'h00, ma} * {6'h00, ma}
                + {6'h00, mb} * {6'h00, mb}; // [R4]
        end
    endfunction

    // ========================================================
    // registers; controls, limits and fade enables one copy per path, page, interp, status and mask shared
    reg page;
    reg [7:0] long_detector_control [0:1];
    reg [7:0] short_detector_control [0:1];
    reg [12:0] long_power_limit [0:1];
    reg [12:0] short_power_limit [0:1];
    reg [1:0] long_error_fade_enable;
    reg [7:0] interp_config;
    reg [3:0] err_status;
    reg [3:0] err_mask;
    reg [11:0] power0;
    reg [11:0] power1;

    wire pa_tick;
    wire [12:0] long_power_reading [0:1];
    wire [12:0] short_power_reading [0:1];
    wire [1:0] long_err;
    wire [1:0] short_err;

    // ========================================================
    // apb decode
    wire setup = psel && !penable;
    wire commit = psel && penable && pready;
    wire [11:0] idx = paddr[13:2];
    wire wr = commit && pwrite && !pslverr;

    function apm_mapped;
        input [11:0] a;
        begin
            case (a)
                `APM_IDX_PAGE, `APM_IDX_FADE_EN, `APM_IDX_LLIM_LO,
                `APM_IDX_LLIM_HI, `APM_IDX_LONG_CTL, `APM_IDX_LPWR_LO,
                `APM_IDX_LPWR_HI, `APM_IDX_SLIM_LO, `APM_IDX_SLIM_HI,
                `APM_IDX_SHORT_CTL, `APM_IDX_SPWR_LO, `APM_IDX_SPWR_HI,
                `APM_IDX_INTERP, `APM_IDX_STATUS, `APM_IDX_MASK:
                    apm_mapped = 1'b1;
                default:
                    apm_mapped = 1'b0;
            endcase
        end
    endfunction

    // ========================================================
    // read mux; reserved bits read zero
    reg [7:0] next_rdata;
    always @* begin
        next_rdata = 8'h00;
        case (idx)
            `APM_IDX_PAGE: begin
                next_rdata = {7'h00, page};
            end
            `APM_IDX_FADE_EN: begin
                next_rdata[`APM_FADE_LONG_BIT] =
                    long_error_fade_enable[page];
            end
            `APM_IDX_LLIM_LO: begin
                next_rdata = long_power_limit[page][7:0]; // [R9]
            end
            `APM_IDX_LLIM_HI: begin
                next_rdata = {3'h0, long_power_limit[page][12:8]};
            end
            `APM_IDX_LONG_CTL: begin
                next_rdata = long_detector_control[page];
            end
            `APM_IDX_LPWR_LO: begin
                next_rdata = long_power_reading[page][7:0]; // [R5]
            end
            `APM_IDX_LPWR_HI: begin
                next_rdata = {3'h0, long_power_reading[page][12:8]}; // [R5]
            end
            `APM_IDX_SLIM_LO: begin
                next_rdata = short_power_limit[page][7:0];
            end
            `APM_IDX_SLIM_HI: begin
                next_rdata = {3'h0, short_power_limit[page][12:8]};
            end
            `APM_IDX_SHORT_CTL: begin
                next_rdata = short_detector_control[page];
            end
            `APM_IDX_SPWR_LO: begin
                next_rdata = short_power_reading[page][7:0]; // [R11]
            end
            `APM_IDX_SPWR_HI: begin
                next_rdata = {3'h0, short_power_reading[page][12:8]}; // [R11]
            end
            `APM_IDX_INTERP: begin
                next_rdata = interp_config;
            end
            `APM_IDX_STATUS: begin
                next_rdata = {4'h0, err_status};
            end
            `APM_IDX_MASK: begin
                next_rdata = {4'h0, err_mask};
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // ========================================================
    // apb handshake: answer in the cycle after setup
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= !apm_mapped(idx);
            prdata <= {24'h000000, next_rdata};
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ========================================================
    // control writes, per-path ones through the page, masked to the documented fields
    integer p;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            page <= `APM_RST_PAGE;
            interp_config <= 8'h00;
            err_mask <= 4'h0;
            for (p = 0; p < 2; p = p + 1) begin
                long_detector_control[p] <= `APM_RST_CTL;
                short_detector_control[p] <= `APM_RST_CTL;
                long_power_limit[p] <= `APM_RST_LIMIT;
                short_power_limit[p] <= `APM_RST_LIMIT;
                long_error_fade_enable[p] <= `APM_RST_FADE_LONG; // [R12]
            end
        end else if (wr) begin
            case (idx)
                `APM_IDX_PAGE: begin
                    page <= pwdata[0];
                end
                `APM_IDX_FADE_EN: begin
                    long_error_fade_enable[page] <=
                        pwdata[`APM_FADE_LONG_BIT];
                end
                `APM_IDX_LLIM_LO: begin
                    long_power_limit[page][7:0] <= pwdata[7:0]; // [R10]
                end
                `APM_IDX_LLIM_HI: begin
                    long_power_limit[page][12:8] <= pwdata[4:0]; // [R10]
                end
                `APM_IDX_LONG_CTL: begin
                    long_detector_control[page] <= {pwdata[7], 3'h0,
                        pwdata[`APM_LONG_LEN_MSB:0]}; // [R9]
                end
                `APM_IDX_SLIM_LO: begin
                    short_power_limit[page][7:0] <= pwdata[7:0]; // [R6]
                end
                `APM_IDX_SLIM_HI: begin
                    short_power_limit[page][12:8] <= pwdata[4:0]; // [R6]
                end
                `APM_IDX_SHORT_CTL: begin
                    short_detector_control[page] <= {pwdata[7], 5'h00,
                        pwdata[`APM_SHORT_LEN_MSB:0]}; // [R9]
                end
                `APM_IDX_INTERP: begin
                    interp_config <= pwdata[7:0];
                end
                `APM_IDX_MASK: begin
                    err_mask <= pwdata[3:0];
                end
                default: begin
                    page <= page;
                end
            endcase
        end
    end

    // ========================================================
    // sample power, registered once per dac clock
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            power0 <= 12'h000;
            power1 <= 12'h000;
        end else begin
            power0 <= apm_iq_power(path0_i[15:10], path0_q[15:10]); // [R4]
            power1 <= apm_iq_power(path1_i[15:10], path1_q[15:10]); // [R4]
        end
    end

    // ========================================================
    // shared pa clock
    apm_pa_clock u_pa_clock (
        .mclk(mclk),
        .rst(rst),
        .main_interp(interp_config[3:0]),
        .chan_interp(interp_config[7:4]),
        .pa_tick(pa_tick)
    );

    // ========================================================
    // two windows per path
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_path
            wire [11:0] pwr = (g == 0) ? power0 : power1;
            wire [7:0] lctl = long_detector_control[g];
            wire [7:0] sctl = short_detector_control[g];

            apm_window_avg u_long (
                .mclk(mclk),
                .rst(rst),
                .enable(lctl[`APM_DET_ON_BIT]), // [R1]
                .pa_tick(pa_tick),
                .shift(`APM_LONG_BASE_EXP
                    + {1'b0, lctl[`APM_LONG_LEN_MSB:0]}), // [R2]
                .limit(long_power_limit[g]), // [R10]
                .power(pwr),
                .avg(long_power_reading[g]),
                .err(long_err[g])
            );

            apm_window_avg u_short (
                .mclk(mclk),
                .rst(rst),
                .enable(sctl[`APM_DET_ON_BIT]), // [R7]
                .pa_tick(pa_tick),
                .shift({3'h0, sctl[`APM_SHORT_LEN_MSB:0]}), // [R8]
                .limit(short_power_limit[g]), // [R6]
                .power(pwr),
                .avg(short_power_reading[g]),
                .err(short_err[g])
            );
        end
    endgenerate

    // ========================================================
    // sticky status: set wins over a write-one clear
    wire [3:0] err_events = {short_err[1], long_err[1],
        short_err[0], long_err[0]};
    wire [3:0] clr = (wr && idx == `APM_IDX_STATUS) ? pwdata[3:0] : 4'h0;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            err_status <= 4'h0;
            irq <= 1'b0;
            fade_request <= 2'b00;
        end else begin
            err_status <= (err_status & ~clr) | err_events; // [R13]
            irq <= |(((err_status & ~clr) | err_events) & err_mask);
            fade_request <= long_err & long_error_fade_enable; // [R12]
        end
    end

endmodule // apm_monitor

/* sim/apm_monitor_properties.sv */
/*
 * Port checker for the power protection monitor: APB answer
 * timing, read data shape, fade pulses and reset quiet state.
 * Assumes the bind below onto every apm_monitor instance.
 */
`timescale 1ns/100ps

module apm_props (
    // clock and reset
    input wire mclk,
    input wire rst,
    // apb
    input wire psel,
    input wire penable,
    input wire [13:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // protection
    input wire [1:0] fade_request,
    input wire irq
);
    // ============================================================
    // helpers
    wire setup = psel && !penable;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ============================================================
    // assertions
    ready_after_setup_a: assert property (setup |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    ready_cause_a: assert property (pready |-> $past(setup))
        else $error("ready without setup");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (
        setup && paddr[13:2] == 12'h7FF |=> pslverr)
        else $error("unmapped access not refused");
    upper_zero_a: assert property (
        pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    read_hold_a: assert property (!$past(setup) |-> $stable(prdata))
        else $error("read data moved outside setup");
    fade_pulse_a: assert property (
        fade_request != 2'h0 |=> fade_request == 2'h0)
        else $error("fade request longer than a pulse");
    quiet_reset_a: assert property (
        $fell(rst) |-> !pready && !irq && fade_request == 2'h0)
        else $error("outputs active after reset");

    cover property (pready && pslverr);
    cover property (fade_request[0]);
    cover property ($rose(irq));
endmodule // apm_props

bind apm_monitor apm_props chk_u (
    .mclk(mclk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .fade_request(fade_request),
    .irq(irq)
);

/* sim/apm_monitor_tb_top.sv */
/*
 * Self-checking bench for the power protection monitor:
 * register map, paging, short and long windows, interrupt.
 * Assumes the port checker is bound in from its own file.
 */
`timescale 1ns/100ps

module apm_monitor_tb_top;
    // ============================================================
    // signals
    reg mclk = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [13:0] paddr = 14'h0000;
    reg [31:0] pwdata = 32'h0;
    reg [15:0] p0_i = 16'h7C00;
    reg [15:0] p0_q = 16'h8000;
    reg [15:0] p1_i = 16'h0000;
    reg [15:0] p1_q = 16'h0000;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [1:0] fade_request;
    wire irq;
    integer failures = 0;
    integer n_checks = 0;
    integer cycles = 0;
    integer fade_seen = 0;
    integer t0;
    reg [31:0] rd;
    reg err;

    always #10 mclk = ~mclk;

    apm_monitor dut_u (
        .mclk(mclk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .path0_i(p0_i),
        .path0_q(p0_q),
        .path1_i(p1_i),
        .path1_q(p1_q),
        .fade_request(fade_request),
        .irq(irq)
    );

    // ============================================================
    // tasks
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask

    task report_and_stop;
        begin
            $display("checks %0d failures %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0) begin
                $display("Finished cleanly");
            end else begin
                $display("Finished with errors");
            end
            $finish;
        end
    endtask

    // one transfer; request held until pready is seen at an edge
    task apb(input wr, input [11:0] idx, input [31:0] d);
        begin
            @(posedge mclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= wr;
            paddr <= {idx, 2'b00};
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            @(posedge mclk);
            while (pready !== 1'b1) @(posedge mclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task wr(input [11:0] idx, input [31:0] d);
        apb(1'b1, idx, d);
    endtask

    task rc(input [11:0] idx, input [31:0] exp);
        begin
            apb(1'b0, idx, 32'h0);
            check(rd, exp);
        end
    endtask

    task wc(input [11:0] idx, input [31:0] d, input [31:0] exp);
        begin
            wr(idx, d);
            rc(idx, exp);
        end
    endtask

    task poll(input [11:0] idx, input [31:0] m, input integer lim);
        integer k;
        begin
            k = 0;
            rd = 32'h0;
            while ((rd & m) == 32'h0 && k < lim) begin
                apb(1'b0, idx, 32'h0);
                k = k + 1;
            end
        end
    endtask

    // ============================================================
    // watchdog and fade monitor
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (fade_request[0] === 1'b1) fade_seen = fade_seen + 1;
        if (cycles == 10000) begin
            failures = failures + 1;
            report_and_stop;
        end
    end

    // ============================================================
    // tests; path 0 power is 31*31 + 32*32 = 0x7C1
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rc(12'h581, 32'h40);
        rc(12'h585, 32'h0);
        rc(12'h587, 32'h0);
        rc(12'h589, 32'h0);
        rc(12'h58A, 32'h0);
        rc(12'h58C, 32'h0);
        wc(12'h589, 32'hFF, 32'h1F);
        wc(12'h584, 32'hFF, 32'h1F);
        wc(12'h585, 32'hFF, 32'h8F);
        wc(12'h58A, 32'hFF, 32'h83);
        wc(12'h587, 32'hFF, 32'h0);
        wc(12'h58B, 32'hFF, 32'h0);
        wc(12'h585, 32'h0, 32'h0);
        wc(12'h58A, 32'h0, 32'h0);
        wc(12'h584, 32'h0, 32'h0);
        wr(12'h7FF, 32'hFF);
        check({31'h0, err}, 32'h1);
        wc(12'h008, 32'h1, 32'h1);
        wc(12'h588, 32'h5A, 32'h5A);
        wc(12'h008, 32'h0, 32'h0);
        rc(12'h588, 32'h0);
        // short window, limit one below the power
        wr(12'h588, 32'hC0);
        wr(12'h589, 32'h07);
        wr(12'h5A2, 32'h02);
        wr(12'h58A, 32'h80);
        poll(12'h5A1, 32'h2, 100);
        check(rd & 32'h2, 32'h2);
        rc(12'h58B, 32'hC1);
        rc(12'h58C, 32'h07);
        check({31'h0, irq}, 32'h1);
        wr(12'h58A, 32'h0);
        wr(12'h5A1, 32'h2);
        rc(12'h5A1, 32'h0);
        check({31'h0, irq}, 32'h0);
        // equal to the limit is not an error
        wr(12'h588, 32'hC1);
        wr(12'h58A, 32'h80);
        repeat (160) @(posedge mclk);
        rc(12'h5A1, 32'h0);
        wr(12'h58A, 32'h0);
        // long window: 512 ticks of 4 x 2 cycles
        wr(12'h5A0, 32'h02);
        wr(12'h5A2, 32'h01);
        t0 = cycles;
        wr(12'h585, 32'h80);
        poll(12'h5A1, 32'h1, 2000);
        check(rd & 32'h1, 32'h1);
        t0 = cycles - t0;
        check({31'h0, t0 >= 4085 && t0 <= 4115}, 32'h1);
        rc(12'h586, 32'hC1);
        rc(12'h587, 32'h07);
        check({31'h0, fade_seen > 0}, 32'h1);
        check({31'h0, irq}, 32'h1);
        wr(12'h585, 32'h0);
        // path 1 short window, channel interpolation: 4 ticks of 8
        // cycles; page 1 limit is 0x5A, path 1 power is 0x400
        p1_i <= 16'h8000;
        wr(12'h5A0, 32'h21);
        wr(12'h008, 32'h1);
        wr(12'h5A2, 32'h08);
        t0 = cycles;
        wr(12'h58A, 32'h82);
        poll(12'h5A1, 32'h8, 100);
        check(rd & 32'h8, 32'h8);
        t0 = cycles - t0;
        check({31'h0, t0 >= 28 && t0 <= 44}, 32'h1);
        rc(12'h58B, 32'h00);
        rc(12'h58C, 32'h04);
        check({31'h0, irq}, 32'h1);
        wr(12'h58A, 32'h0);
        wr(12'h008, 32'h0);
        report_and_stop;
    end
endmodule // apm_monitor_tb_top
